// >>> rtl/pmsc_pkg.sv
// Constants and types for the processor mode status register block.
// Summary of operation
// R1: Bits 15..7 select 128-word vector page.
// R2: Hardware reset sets vector pointer to all ones.
// R3: Software reset leaves vector pointer unchanged.
// R4: Bit 6 one removes ROM from program.
// R5: ROM-disable bit loaded from pin at reset.
// R6: Software may write ROM bit; soft reset keeps.
// R7: Bit 5 overlays RAM into program, except page0.
// R8: Bit 4 one drives program address out.
// R9: Bit 4 zero holds last external address.
// R10: Bit 2 one holds clock output high.
// R11: Bit 1 saturates product before accumulate.
// R12: Product saturation only with overflow and fractional.
// R13: Bit 0 saturates accumulator before store.
// R14: Store shifts first, then saturates.
// R15: Vectors relocate to start of selected page.
// R16: Overlay RAM spans data 0080h to 3FFFh.
// R17: Reset clears overlay, visibility, clock-off, reserved.
package pmsc_pkg;
  localparam logic [11:0] PMSC_MODE_OFFSET = 12'h000;
  localparam logic [11:0] PMSC_CORE_OFFSET = 12'h004;
  localparam int PMSC_VPP_MSB = 15;
  localparam int PMSC_VPP_LSB = 7;
  localparam int PMSC_ROMDIS_BIT = 6;
  localparam int PMSC_OVERLAY_BIT = 5;
  localparam int PMSC_VISIBLE_BIT = 4;
  localparam int PMSC_CLK_OFF_BIT = 2;
  localparam int PMSC_MUL_SAT_BIT = 1;
  localparam int PMSC_STORE_SAT_BIT = 0;
  localparam logic [8:0] PMSC_VPP_RESET = 9'h1FF;
  localparam logic [1:0] PMSC_STRAP_FILL = 2'h3;
  localparam logic [15:0] PMSC_WRITE_MASK = 16'hFFF7;
  localparam logic [15:0] PMSC_RAM_LO = 16'h0080;
  localparam logic [15:0] PMSC_RAM_HI = 16'h3FFF;
  localparam logic [15:0] PMSC_ROM_LO = 16'hC000;
  localparam logic [31:0] PMSC_SAT_POS = 32'h7FFFFFFF;
  localparam logic [31:0] PMSC_SAT_NEG = 32'h80000000;
  localparam int PMSC_CLK_HZ = 50000000;

  typedef struct packed {
    logic [8:0] vector_page_pointer;
    logic rom_disable_mode;
    logic ram_overlay;
    logic address_visibility;
    logic reserved3;
    logic clock_output_off;
    logic multiply_saturation;
    logic store_saturation;
  } pmsc_mode_t;

  typedef struct packed {
    logic overflow_mode_flag;
    logic fractional_mode_flag;
    logic soft_reset;
  } pmsc_core_t;
endpackage : pmsc_pkg

// >>> rtl/pmsc_top.sv
// Processor mode status register with APB access, memory decode and saturation.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmsc_top
  import pmsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic soft_reset_exec,
  input wire logic [15:0] prog_addr,
  input wire logic prog_addr_valid,
  input wire logic [15:0] ext_addr_in,
  input wire logic ext_addr_valid,
  input wire logic [15:0] data_addr,
  input wire logic rom_disable_pin,
  input wire logic clk_src,
  input wire logic [31:0] product,
  input wire logic [39:0] acc_in,
  input wire logic [4:0] store_shift,
  // Decode and pins
  output logic [15:0] vector_base,
  output logic rom_prog_sel,
  output logic ram_prog_sel,
  output logic ram_data_sel,
  output logic [15:0] ext_addr_pins,
  output logic clock_output_pin,
  output logic [31:0] product_out,
  output logic [31:0] store_out
);

  // The block keeps one 16-bit mode register and a small flag register on the bus.
  // Every output is registered, so decode and saturation results lag their inputs by one edge.
  // The mode pin and the clock source are asynchronous and pass three flip-flops each.
  // Soft reset reaches only a status record; it never touches the mode register.

  // Register state.
  pmsc_mode_t mode_r;
  pmsc_core_t core_r;
  logic [2:0] pin_sync_r;
  logic [2:0] clk_sync_r;
  logic [1:0] strap_cnt_r;
  logic strap_pending_r;

  // Next values and decode terms.
  pmsc_mode_t mode_nxt;
  pmsc_core_t core_nxt;
  logic [15:0] mode_wr_val;
  logic [31:0] rd_word_nxt;
  logic [15:0] ext_addr_nxt;
  logic clk_out_nxt;
  logic [31:0] product_nxt;
  logic [31:0] store_nxt;
  logic strap_take;
  logic pin_stable;
  logic clk_stable;
  logic apb_setup;
  logic apb_access;
  logic wr_mode;
  logic wr_core;
  logic rd_hit;
  logic prog_in_rom;
  logic prog_in_ram;
  logic data_in_ram;
  logic sat_mul;
  logic prod_at_min;
  logic store_over_pos;
  logic store_over_neg;
  logic [39:0] shifted;

  // Bus phases: a write lands on the access edge, the same edge at which pready is seen high.
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign wr_mode = apb_access && pwrite && (paddr == PMSC_MODE_OFFSET);
  assign wr_core = apb_access && pwrite && (paddr == PMSC_CORE_OFFSET);
  assign rd_hit = (paddr == PMSC_MODE_OFFSET) || (paddr == PMSC_CORE_OFFSET);

  // Write data for the mode register, one bit at a time through the write mask.
  // The reserved bit can never take a one this way.
  for (genvar b = 0; b < 16; b++) begin : g_mode_wr
    assign mode_wr_val[b] = PMSC_WRITE_MASK[b] & pwdata[b]; // R17
  end

  // The mode pin is an asynchronous strap and passes three flip-flops.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], rom_disable_pin};
    end
  end

  assign pin_stable = (pin_sync_r[2] == pin_sync_r[1]);

  // The fill counter keeps the strap from taking the reset value of the synchroniser.
  // Without it the first edge after reset would see two equal zeros and take them.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_r <= 2'h0;
    end else if (strap_cnt_r != PMSC_STRAP_FILL) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  assign strap_take = strap_pending_r && (strap_cnt_r == PMSC_STRAP_FILL) && pin_stable;

  // The pin is taken once per reset and never looked at again.
  // A software write inside the window wins and closes the window too.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_pending_r <= 1'b1;
    end else if (strap_take || wr_mode) begin
      strap_pending_r <= 1'b0; // R5
    end
  end

  // Next mode value; only a bus write or the strap can change it.
  // No soft reset term appears here, so that instruction leaves every field alone.
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = pmsc_mode_t'(mode_wr_val); // R6 R15
    end else if (strap_take) begin
      mode_nxt.rom_disable_mode = pin_sync_r[2]; // R5
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= '0; // R17
      mode_r.vector_page_pointer <= PMSC_VPP_RESET; // R2
    end else begin
      mode_r <= mode_nxt; // R3
    end
  end

  // Flags that qualify product saturation, and a record of the soft reset input.
  always_comb begin
    core_nxt = core_r;
    if (wr_core) begin
      core_nxt.overflow_mode_flag = pwdata[2];
      core_nxt.fractional_mode_flag = pwdata[1];
    end
    core_nxt.soft_reset = soft_reset_exec;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Read mux, looked at in the setup cycle so that data stands at the access edge.
  // The reserved bit is masked so that it always reads zero.
  always_comb begin
    rd_word_nxt = 32'h00000000;
    if (paddr == PMSC_MODE_OFFSET) begin
      rd_word_nxt = {16'h0000, mode_r & PMSC_WRITE_MASK}; // R17
    end else if (paddr == PMSC_CORE_OFFSET) begin
      rd_word_nxt = {29'h0, core_r.overflow_mode_flag, core_r.fractional_mode_flag, core_r.soft_reset};
    end
  end

  // Zero wait states: pready follows every setup cycle by one edge.
  // The access cycle never raises it, so back-to-back transfers are safe.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup;
    end
  end

  // Unmapped addresses answer with an error; a write to them changes nothing.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_setup && !rd_hit;
    end
  end

  // Read data holds until the next read setup.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_word_nxt;
    end
  end

  // Address ranges for the memory decode.
  assign prog_in_rom = (prog_addr >= PMSC_ROM_LO);
  assign prog_in_ram = (prog_addr >= PMSC_RAM_LO) && (prog_addr <= PMSC_RAM_HI);
  assign data_in_ram = (data_addr >= PMSC_RAM_LO) && (data_addr <= PMSC_RAM_HI);

  // Vector table base: the pointer selects a 128-word page.
  // It follows the pointer one edge later, so the output comes from a flip-flop.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vector_base <= {PMSC_VPP_RESET, 7'h00};
    end else begin
      vector_base <= {mode_r.vector_page_pointer, 7'h00}; // R1 R15
    end
  end

  // The ROM is assumed to fill the top quarter of program space.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_prog_sel <= 1'b0;
    end else begin
      rom_prog_sel <= !mode_r.rom_disable_mode && prog_in_rom; // R4
    end
  end

  // Data page 0 lies below the range and so never appears in program space.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_prog_sel <= 1'b0;
    end else begin
      ram_prog_sel <= mode_r.ram_overlay && prog_in_ram; // R7
    end
  end

  // The dual-access RAM is always decoded in data space.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_data_sel <= 1'b0;
    end else begin
      ram_data_sel <= data_in_ram; // R16
    end
  end

  // External address pins follow program addresses only when visible.
  // A real external access always moves them; otherwise the last address stays.
  always_comb begin
    ext_addr_nxt = ext_addr_pins;
    if (ext_addr_valid) begin
      ext_addr_nxt = ext_addr_in;
    end else if (mode_r.address_visibility && prog_addr_valid) begin
      ext_addr_nxt = prog_addr; // R8
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_addr_pins <= 16'h0000;
    end else begin
      ext_addr_pins <= ext_addr_nxt; // R9
    end
  end

  // The clock source is asynchronous and passes three flip-flops.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_sync_r <= 3'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], clk_src};
    end
  end

  assign clk_stable = (clk_sync_r[2] == clk_sync_r[1]);

  // A level counts only once the last two stages agree; the stop bit overrides it.
  always_comb begin
    clk_out_nxt = clock_output_pin;
    if (mode_r.clock_output_off) begin
      clk_out_nxt = 1'b1; // R10
    end else if (clk_stable) begin
      clk_out_nxt = clk_sync_r[2];
    end
  end

  // Reset leaves the pin high, the level at which it also rests when stopped.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_output_pin <= 1'b1;
    end else begin
      clock_output_pin <= clk_out_nxt;
    end
  end

  // Saturation terms; the store value is shifted before its range is judged.
  assign sat_mul = mode_r.multiply_saturation && core_r.overflow_mode_flag && core_r.fractional_mode_flag; // R12
  assign prod_at_min = (product == PMSC_SAT_NEG);
  assign shifted = acc_in <<< store_shift; // R14
  assign store_over_pos = !shifted[39] && (shifted[38:31] != 8'h00);
  assign store_over_neg = shifted[39] && (shifted[38:31] != 8'hFF);

  // Product saturation before accumulation.
  // Only the most negative product can leave the fractional range.
  always_comb begin
    product_nxt = product;
    if (sat_mul && prod_at_min) begin
      product_nxt = PMSC_SAT_POS; // R11
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      product_out <= 32'h00000000;
    end else begin
      product_out <= product_nxt;
    end
  end

  // Store saturation clamps the shifted accumulator to a 32-bit signed word.
  // Without it the upper bits are simply dropped.
  always_comb begin
    store_nxt = shifted[31:0];
    if (mode_r.store_saturation && store_over_pos) begin
      store_nxt = PMSC_SAT_POS; // R13
    end else if (mode_r.store_saturation && store_over_neg) begin
      store_nxt = PMSC_SAT_NEG; // R13
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_out <= 32'h00000000;
    end else begin
      store_out <= store_nxt;
    end
  end

endmodule : pmsc_top
`default_nettype wire

// >>> dv/pmsc_core_model.sv
// Far-side model: clock source feeding the clock output pin.
`timescale 1ns/1ps
`default_nettype none
module pmsc_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Toward the block
  output logic clk_src
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_src <= 1'b0;
    end else begin
      clk_src <= ~clk_src;
    end
  end
endmodule : pmsc_core_model
`default_nettype wire

// >>> dv/pmsc_sva.sv
// Port assertions for the mode register block.
`timescale 1ns/1ps
`default_nettype none
module pmsc_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic [15:0] prog_addr,
  input wire logic [31:0] product,
  input wire logic [31:0] product_out,
  input wire logic [15:0] vector_base,
  input wire logic rom_prog_sel,
  input wire logic ram_prog_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ready_time_a: assert property (psel && !penable |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  bad_addr_a: assert property (pready && paddr != 12'h000 && paddr != 12'h004 |-> pslverr) else $error("no error");
  vec_align_a: assert property (psel && penable && pwrite && paddr == 12'h000 |-> ##2 vector_base == {$past(pwdata[15:7], 2), 7'h00}) else $error("vector base");
  vec_reset_a: assert property (disable iff (1'b0) $past(sys_rst) |-> vector_base == 16'hFF80) else $error("reset vector");
  rom_range_a: assert property (rom_prog_sel |-> $past(prog_addr) >= 16'hC000) else $error("rom decode");
  ram_range_a: assert property (ram_prog_sel |-> $past(prog_addr) inside {[16'h0080:16'h3FFF]}) else $error("ram decode");
  prod_pass_a: assert property (!$past(sys_rst) && $past(product) != 32'h80000000 |-> product_out == $past(product))
    else $error("product");
endmodule : pmsc_sva
bind pmsc_top pmsc_sva chk (.*);
`default_nettype wire

// >>> dv/pmsc_tb_top.sv
// Self-checking bench for the mode register block.
`timescale 1ns/1ps
`default_nettype none
module pmsc_tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_addr_valid = 1'b0;
  logic [15:0] ext_addr_in = 16'h1234;
  logic psel, penable, pwrite, soft_reset_exec, prog_addr_valid, rom_disable_pin, slv, pready, pslverr;
  logic rom_prog_sel, ram_prog_sel, ram_data_sel, clock_output_pin, clk_src;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, product, product_out, store_out, rd;
  logic [15:0] prog_addr, data_addr, vector_base, ext_addr_pins, v, a, ep;
  logic [39:0] acc_in;
  logic [4:0] store_shift;
  logic [15:0] tab [4] = '{16'h007F, 16'h0080, 16'h3FFF, 16'hC000};
  integer err_count = 0, checked = 0, cyc = 0, seed = 32'hE7D6, i, j;
  pmsc_top uut (.*);
  pmsc_core_model peer (.*);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 5000) begin
    err_count++;
    report_and_stop();
  end
  function automatic logic [31:0] st_exp(input logic [39:0] x, input logic [4:0] s);
    logic signed [39:0] y;
    y = x << s;
    if (y > 40'sh007FFFFFFF) return 32'h7FFFFFFF;
    if (y < -40'sh0080000000) return 32'h80000000;
    return y[31:0];
  endfunction : st_exp
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task report_and_stop;
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    {psel, penable, pwrite, paddr, pwdata, soft_reset_exec, prog_addr_valid} = '0;
    {prog_addr, data_addr, product, acc_in, store_shift, ep} = '0;
    rom_disable_pin = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rom_disable_pin <= 1'b0;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000FFC0);
    chk(vector_base, 16'hFF80);
    apb(0, 12'h010, 0);
    chk({rd[30:0], slv}, 1);
    for (i = 0; i < 8; i++) begin
      v = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed));
      apb(1, 12'h000, {16'h0000, v});
      apb(0, 12'h000, 0);
      chk(rd, v & 16'hFFF7);
      chk(vector_base, {v[15:7], 7'h00});
      for (j = 0; j < 4; j++) begin
        a = tab[j];
        @(posedge ref_clk);
        {prog_addr_valid, prog_addr, data_addr} <= {1'b1, a, a};
        @(posedge ref_clk);
        @(negedge ref_clk);
        ep = v[4] ? a : ep;
        chk(rom_prog_sel, !v[6] && a >= 16'hC000);
        chk(ram_prog_sel, v[5] && a inside {[16'h0080:16'h3FFF]});
        chk(ram_data_sel, a inside {[16'h0080:16'h3FFF]});
        chk(ext_addr_pins, ep);
        chk(clock_output_pin | !v[2], 1);
      end
    end
    apb(1, 12'h000, 32'h0000A5C3);
    soft_reset_exec <= 1'b1;
    @(posedge ref_clk);
    soft_reset_exec <= 1'b0;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000A5C3);
    for (i = 0; i < 8; i++) begin
      apb(1, 12'h004, {29'h0, i[1:0], 1'b0});
      product <= i[2] ? $random(seed) : 32'h80000000;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(product_out, i[1:0] == 2'b11 && product == 32'h80000000 ? 32'h7FFFFFFF : product);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      acc_in <= i == 0 ? 40'h0040000000 : {8'($random(seed)), $random(seed)};
      store_shift <= i == 0 ? 5'h01 : 5'($random(seed));
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(store_out, st_exp(acc_in, store_shift));
    end
    report_and_stop();
  end
endmodule : pmsc_tb_top
`default_nettype wire
